// ===== verilog/cts_pkg.sv
// Constants and types for the conditional table selector.
// Assumes a 32-bit APB slave port and signed 32-bit source values.
package cts_pkg;
	localparam int CTS_NUM_TYPES = 15;
	localparam int CTS_NUM_INST = 16;
	localparam int CTS_NUM_SLOTS = 3;
	localparam int CTS_NUM_COND = 3;
	localparam logic [3:0] CTS_SRC_UNUSED = 4'h0;
	localparam logic [3:0] CTS_SRC_LOOKUP = 4'h3;
	localparam logic [3:0] CTS_NUM_TABLES = 4'hA;
	// Register byte offsets
	localparam logic [7:0] CTS_OFF_CTRL = 8'h00;
	localparam logic [7:0] CTS_OFF_SLOT0 = 8'h04;
	localparam logic [7:0] CTS_OFF_COND0 = 8'h10;
	localparam logic [7:0] CTS_OFF_STATUS = 8'h40;
	localparam logic [7:0] CTS_OFF_OUT = 8'h44;
	// Field positions
	localparam int CTS_CTRL_EN_BIT = 0;
	localparam int CTS_ST_SLOT_LSB = 0;
	localparam int CTS_ST_EN_BIT = 2;
	localparam int CTS_ST_MATCH_LSB = 4;
	// Comparison operator codes
	localparam logic [2:0] CTS_CMP_EQ = 3'h0;
	localparam logic [2:0] CTS_CMP_NE = 3'h1;
	localparam logic [2:0] CTS_CMP_GT = 3'h2;
	localparam logic [2:0] CTS_CMP_GE = 3'h3;
	localparam logic [2:0] CTS_CMP_LT = 3'h4;
	localparam logic [2:0] CTS_CMP_LE = 3'h5;
	// Combining operator codes
	localparam logic [2:0] CTS_LOG_DEFAULT = 3'h0;
	localparam logic [2:0] CTS_LOG_AND3 = 3'h1;
	localparam logic [2:0] CTS_LOG_OR3 = 3'h2;
	localparam logic [2:0] CTS_LOG_ANDOR = 3'h3;
	localparam logic [2:0] CTS_LOG_ORAND = 3'h4;

	typedef struct packed {
		logic [2:0] cmp_op;
		logic [7:0] num2;
		logic [3:0] src2;
		logic [7:0] num1;
		logic [3:0] src1;
	} cts_cond_t;

	typedef struct packed {
		logic [2:0] logic_op;
		logic [3:0] table_num;
	} cts_slot_t;

	localparam cts_cond_t CTS_COND_RST = '0;
	localparam cts_slot_t CTS_SLOT_RST = '0;
endpackage

// ===== verilog/cts_selector.sv
// Conditional table selector: picks one of three lookup-table outputs.
// Assumes source values arrive synchronous to pclk, indexed by type and instance.
//
// Design decisions made here: the APB register port and the register addresses.
module cts_selector
	import cts_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic signed [31:0] src_val [CTS_NUM_TYPES][CTS_NUM_INST],
	output logic signed [31:0] sel_out,
	output logic [1:0] sel_slot,
	output logic sel_active
);

	logic en_r;
	logic en_nxt;
	cts_slot_t slot_r [CTS_NUM_SLOTS];
	cts_slot_t slot_nxt [CTS_NUM_SLOTS];
	cts_cond_t cond_r [CTS_NUM_SLOTS*CTS_NUM_COND];
	cts_cond_t cond_nxt [CTS_NUM_SLOTS*CTS_NUM_COND];
	logic [31:0] prdata_r;
	logic [31:0] prdata_nxt;
	logic signed [31:0] out_r;
	logic signed [31:0] out_nxt;
	logic [1:0] slot_sel_r;
	logic [1:0] slot_sel_nxt;
	logic [2:0] match;
	logic [2:0] match_r;
	logic [2:0] match_nxt;
	logic wr_en;
	logic addr_ok;

	// Byte-lane merge of a write into a stored word
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[8*b +: 8] = wd[8*b +: 8];
			end
		end
		return res;
	endfunction

	// Looks up one source signal; out-of-range picks read as zero
	function automatic logic signed [31:0] arg_value(input logic [3:0] src,
		input logic [7:0] num);
		logic [7:0] idx;
		logic signed [31:0] v;
		idx = (num == 8'h00) ? 8'h00 : num - 8'h01;
		v = '0;
		if (src == CTS_SRC_UNUSED) begin
			v = '0;
		end else if ({28'h0000000, src} < CTS_NUM_TYPES && {24'h000000, idx} < CTS_NUM_INST) begin
			v = src_val[src][idx[3:0]];
		end
		return v;
	endfunction

	function automatic logic compare(input logic [2:0] op, input logic signed [31:0] a,
		input logic signed [31:0] b);
		logic r;
		case (op)
			CTS_CMP_EQ: r = (a == b);
			CTS_CMP_NE: r = (a != b);
			CTS_CMP_GT: r = (a > b);
			CTS_CMP_GE: r = (a >= b);
			CTS_CMP_LT: r = (a < b);
			CTS_CMP_LE: r = (a <= b);
			default: r = 1'b0;
		endcase
		return r;
	endfunction

	function automatic logic combine(input logic [2:0] op, input logic [2:0] c);
		logic r;
		case (op)
			CTS_LOG_DEFAULT: r = 1'b1;
			CTS_LOG_AND3: r = c[0] & c[1] & c[2];
			CTS_LOG_OR3: r = c[0] | c[1] | c[2];
			CTS_LOG_ANDOR: r = (c[0] & c[1]) | c[2];
			CTS_LOG_ORAND: r = (c[0] | c[1]) & c[2];
			default: r = 1'b0;
		endcase
		return r;
	endfunction

	// Output of the lookup table a slot names; bad numbers give zero
	function automatic logic signed [31:0] table_value(input logic [3:0] tnum);
		logic signed [31:0] v;
		v = '0;
		if (tnum != 4'h0 && tnum <= CTS_NUM_TABLES) begin
			v = src_val[CTS_SRC_LOOKUP][tnum - 4'h1];
		end
		return v;
	endfunction

	// Slot evaluation
	always_comb begin
		logic [2:0] c;
		c = '0;
		for (int s = 0; s < CTS_NUM_SLOTS; s++) begin
			for (int k = 0; k < CTS_NUM_COND; k++) begin
				c[k] = compare(cond_r[s*CTS_NUM_COND+k].cmp_op,
					arg_value(cond_r[s*CTS_NUM_COND+k].src1, cond_r[s*CTS_NUM_COND+k].num1),
					arg_value(cond_r[s*CTS_NUM_COND+k].src2,
					cond_r[s*CTS_NUM_COND+k].num2));
			end
			match[s] = combine(slot_r[s].logic_op, c);
		end
	end

	// Priority pick and registered output
	always_comb begin
		slot_sel_nxt = 2'd0;
		if (match[0]) begin
			slot_sel_nxt = 2'd0;
		end else if (match[1]) begin
			slot_sel_nxt = 2'd1;
		end else if (match[2]) begin
			slot_sel_nxt = 2'd2;
		end
		match_nxt = match;
		out_nxt = '0;
		if (en_r) begin
			out_nxt = table_value(slot_r[slot_sel_nxt].table_num);
		end else begin
			slot_sel_nxt = 2'd0;
			match_nxt = '0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_r <= '0;
			slot_sel_r <= 2'd0;
			match_r <= '0;
		end else begin
			out_r <= out_nxt;
			slot_sel_r <= slot_sel_nxt;
			match_r <= match_nxt;
		end
	end

	assign sel_out = out_r;
	assign sel_slot = slot_sel_r;
	assign sel_active = en_r;

	// APB slave
	// Read data is captured in the setup cycle so prdata comes from a flop
	assign addr_ok = (paddr[1:0] == 2'b00) && (paddr <= CTS_OFF_OUT)
		&& !(paddr > (CTS_OFF_COND0 + 8'h20) && paddr < CTS_OFF_STATUS);
	assign wr_en = psel & penable & pwrite & addr_ok;
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~addr_ok;
	assign prdata = prdata_r;

	always_comb begin
		logic [31:0] w;
		w = '0;
		en_nxt = en_r;
		slot_nxt = slot_r;
		cond_nxt = cond_r;
		if (wr_en) begin
			if (paddr == CTS_OFF_CTRL) begin
				w = merge({31'h0, en_r}, pwdata, pstrb);
				en_nxt = w[CTS_CTRL_EN_BIT];
			end
			for (int s = 0; s < CTS_NUM_SLOTS; s++) begin
				if (paddr == CTS_OFF_SLOT0 + 8'(4*s)) begin
					w = merge({25'h0, slot_r[s]}, pwdata, pstrb);
					slot_nxt[s] = cts_slot_t'(w[$bits(cts_slot_t)-1:0]);
				end
			end
			for (int i = 0; i < CTS_NUM_SLOTS*CTS_NUM_COND; i++) begin
				if (paddr == CTS_OFF_COND0 + 8'(4*i)) begin
					w = merge({5'h0, cond_r[i]}, pwdata, pstrb);
					cond_nxt[i] = cts_cond_t'(w[$bits(cts_cond_t)-1:0]);
				end
			end
		end
	end

	always_comb begin
		prdata_nxt = prdata_r;
		if (psel && !penable) begin
			prdata_nxt = '0;
			if (paddr == CTS_OFF_CTRL) begin
				prdata_nxt[CTS_CTRL_EN_BIT] = en_r;
			end
			if (paddr == CTS_OFF_STATUS) begin
				prdata_nxt[CTS_ST_SLOT_LSB +: 2] = slot_sel_r;
				prdata_nxt[CTS_ST_EN_BIT] = en_r;
				prdata_nxt[CTS_ST_MATCH_LSB +: 3] = match_r;
			end
			if (paddr == CTS_OFF_OUT) begin
				prdata_nxt = out_r;
			end
			for (int s = 0; s < CTS_NUM_SLOTS; s++) begin
				if (paddr == CTS_OFF_SLOT0 + 8'(4*s)) begin
					prdata_nxt = {25'h0, slot_r[s]};
				end
			end
			for (int i = 0; i < CTS_NUM_SLOTS*CTS_NUM_COND; i++) begin
				if (paddr == CTS_OFF_COND0 + 8'(4*i)) begin
					prdata_nxt = {5'h0, cond_r[i]};
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			en_r <= 1'b0;
			prdata_r <= '0;
			for (int s = 0; s < CTS_NUM_SLOTS; s++) begin
				slot_r[s] <= CTS_SLOT_RST;
			end
			for (int i = 0; i < CTS_NUM_SLOTS*CTS_NUM_COND; i++) begin
				cond_r[i] <= CTS_COND_RST;
			end
		end else begin
			en_r <= en_nxt;
			prdata_r <= prdata_nxt;
			slot_r <= slot_nxt;
			cond_r <= cond_nxt;
		end
	end

endmodule

// ===== tb/cts_selector_properties.sv
// Port checker for the table selector.
// Bound to cts_selector from the bench top; one clock domain.
module cts_selector_properties
	import cts_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic signed [31:0] sel_out,
	input wire logic [1:0] sel_slot,
	input wire logic sel_active
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	wire logic acc = psel && penable;
	wire logic rd = acc && !pwrite;
	property p_rdy; pready; endproperty
	property p_en; acc && pwrite && paddr == CTS_OFF_CTRL && pstrb[0]
		|=> sel_active == $past(pwdata[0]); endproperty
	property p_dis; !sel_active && !$past(sel_active) |-> sel_out == 0 && sel_slot == 0;
	endproperty
	property p_slot; sel_slot != 2'h3; endproperty
	property p_out; rd && paddr == CTS_OFF_OUT |-> prdata == $past(sel_out); endproperty
	property p_st; rd && paddr == CTS_OFF_STATUS
		|-> prdata[2:0] == {$past(sel_active), $past(sel_slot)}; endproperty
	property p_unm; acc && paddr == 8'h34 |-> pslverr && (pwrite || prdata == 32'h0);
	endproperty
	property p_setup; psel && !penable |-> !pslverr; endproperty
	a_rdy: assert property (p_rdy) else $error("ready low");
	a_en: assert property (p_en) else $error("enable not taken");
	a_dis: assert property (p_dis) else $error("output while off");
	a_slot: assert property (p_slot) else $error("bad slot");
	a_out: assert property (p_out) else $error("out readback");
	a_st: assert property (p_st) else $error("status readback");
	a_unm: assert property (p_unm) else $error("unmapped access");
	a_setup: assert property (p_setup) else $error("early error");
	c_s2: cover property (sel_slot == 2'h2);
	c_err: cover property (pslverr);
	c_en: cover property ($rose(sel_active));
endmodule

// ===== tb/cts_lut_model.sv
// Far side: lookup table and constant outputs feeding the selector.
// Registered each pclk edge, like the function blocks it stands for.
module cts_lut_model
	import cts_pkg::*;
(
	input wire logic pclk,
	input wire logic signed [31:0] lut_x,
	output logic signed [31:0] src_val [CTS_NUM_TYPES][CTS_NUM_INST]
);
	timeunit 1ns;
	timeprecision 1ps;
	always_ff @(posedge pclk) begin
		for (int t = 0; t < CTS_NUM_TYPES; t++) begin
			for (int i = 0; i < CTS_NUM_INST; i++) begin
				// Other types nonzero except type 8 instance 0, so an unused argument cannot pass by luck
				if (t == 3) src_val[t][i] <= lut_x + 32'(100 * i);
				else src_val[t][i] <= 32'(10 * i + (t == 8 ? 0 : 5));
			end
		end
	end
endmodule

// ===== tb/tb_top.sv
// Self-checking bench for the table selector.
// Drives APB and table inputs by non-blocking assignment at rising edges.
module tb_top
	import cts_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, e;
	logic [7:0] paddr = '0;
	logic [31:0] pwdata = '0, q, prdata;
	logic [3:0] pstrb = 4'hF;
	logic [1:0] sel_slot;
	logic sel_active;
	logic signed [31:0] lut_x = 0, sel_out;
	logic signed [31:0] src_val [CTS_NUM_TYPES][CTS_NUM_INST];
	int mismatches = 0, checks = 0, cyc = 0;
	// Ops c1 c2 c3, combine op, table value, expected slot
	logic [27:0] rows [19] = '{28'h0662140, 28'h0662151, 28'h1662141, 28'h1662130,
		28'h2662150, 28'h2662141, 28'h3662140, 28'h3662131, 28'h4662130, 28'h4662141,
		28'h5662140, 28'h5662151, 28'h5301140, 28'h5301151, 28'h5323131, 28'h5323150,
		28'h0234140, 28'h0244151, 28'h0005141};
	always #4 pclk = ~pclk;
	cts_lut_model i_cts_lut_model (.pclk, .lut_x, .src_val);
	cts_selector i_cts_selector (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
		.pstrb, .prdata, .pready, .pslverr, .src_val, .sel_out, .sel_slot, .sel_active);
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch at %0t: saw %h wanted %h", $time, seen, exp);
		end
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	// Table model and selector each add one edge
	task automatic sel(input logic [1:0] s, input logic [31:0] o);
		repeat (3) @(posedge pclk);
		chk(32'(sel_slot), 32'(s));
		chk(sel_out, o);
	endtask
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 3000) begin
			mismatches++;
			final_report();
		end
	end
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk(32'(sel_active), 0);
		apb(0, CTS_OFF_CTRL, 0);
		chk(q, 0);
		apb(1, CTS_OFF_CTRL, 1);
		apb(1, 8'h08, 32'h02);
		for (int i = 0; i < 19; i++) begin
			lut_x <= 32'(rows[i][11:4]);
			apb(1, CTS_OFF_SLOT0, {25'h0, rows[i][14:12], 4'h1});
			for (int c = 0; c < 3; c++)
				apb(1, 8'(CTS_OFF_COND0 + 4 * c), {5'h0, rows[i][26 - 4 * c -: 3], 24'h038013});
			sel(rows[i][1:0], 32'(rows[i][11:4]) + (rows[i][0] ? 100 : 0));
			$display("row %0d done", i);
		end
		lut_x <= 19;
		apb(1, 8'h08, 32'h52);
		apb(1, 8'h0C, 32'h03);
		sel(2, 219);
		apb(1, 8'h0C, 32'h53);
		sel(0, 19);
		apb(1, 8'h08, 32'h02);
		apb(1, CTS_OFF_COND0, 32'h00018000);
		apb(1, CTS_OFF_SLOT0, 32'h21);
		sel(0, 19);
		apb(0, CTS_OFF_STATUS, 0);
		chk(q & 32'h77, 32'h34);
		apb(0, CTS_OFF_OUT, 0);
		chk(q, 19);
		apb(0, 8'h34, 0);
		chk(q, 0);
		chk(32'(e), 1);
		apb(1, CTS_OFF_CTRL, 0);
		sel(0, 0);
		apb(1, CTS_OFF_CTRL, 1);
		presetn <= 1'b0;
		@(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk(32'(sel_active), 0);
		sel(0, 0);
		$display("hand tests done");
		final_report();
	end
endmodule
bind cts_selector cts_selector_properties i_cts_selector_properties (.pclk, .presetn, .paddr,
	.psel, .penable, .pwrite, .pwdata, .pstrb, .prdata, .pready, .pslverr, .sel_out,
	.sel_slot, .sel_active);
